/* File: verilog/rgh_defines.vh */
// constants for the reading gate and handshake control block
// included by the control block and its result buffer
`ifndef RGH_DEFINES_VH
`define RGH_DEFINES_VH

// activation parameter byte offset and values
`define RGH_ACT_MODE_OFS 3'h0
`define RGH_ACT_MODE_PLAIN 8'h00
`define RGH_ACT_MODE_ACK 8'h01
`define RGH_ACT_MODE_RST 8'h00

// gate control parameter byte offsets
`define RGH_GATE_AUTO_OFS 3'h0
`define RGH_GATE_END_OFS 3'h1
`define RGH_GATE_DLY_LO_OFS 3'h2
`define RGH_GATE_DLY_HI_OFS 3'h3
`define RGH_GATE_MAX_LO_OFS 3'h4
`define RGH_GATE_MAX_HI_OFS 3'h5

// gate control reset values
`define RGH_GATE_AUTO_RST 8'h00
`define RGH_GATE_END_RST 8'h01
`define RGH_GATE_DLY_RST 16'h0000
`define RGH_GATE_MAX_RST 16'h0000
`define RGH_AUTO_ON 8'h01

// gate end mode codes
`define RGH_END_NONE 8'h00
`define RGH_END_COUNT 8'h01
`define RGH_END_TABLE 8'h02
`define RGH_END_IDENT 8'h03
`define RGH_END_REFCMP 8'h04

// control byte bit positions
`define RGH_CTL_GATE_BIT 0
`define RGH_CTL_ACK_BIT 4
`define RGH_CTL_RST_BIT 5

// decoder state image bit positions
`define RGH_ST_GATE_BIT 0
`define RGH_ST_NEW_BIT 1
`define RGH_ST_MORE_BIT 3
`define RGH_ST_OVF_BIT 4

// result word width
`define RGH_RES_W 32

// timing: clock period and millisecond in ns
`define RGH_CLK_PERIOD_NS 40
`define RGH_MS_NS 1000000
`define RGH_CYC_PER_MS (`RGH_MS_NS / `RGH_CLK_PERIOD_NS)

`endif

/* File: verilog/rgh_fifo2.v */
// two-entry result buffer with valid and ready on both sides
// assumes one clock and a synchronous active low reset
`timescale 1ns/10ps
`include "rgh_defines.vh"

module rgh_fifo2 #(
  parameter WIDTH = `RGH_RES_W
) (
  // clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // flush drops every stored entry
  input wire flush_i,
  // fill side
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output wire in_ready_o,
  // drain side
  output wire out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input wire out_ready_i
);

  reg [WIDTH-1:0] mem_q [0:1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] count_q;
  wire push;
  wire pop;
  genvar gi;

  assign in_ready_o = (count_q != 2'd2) && !flush_i;
  assign out_valid_o = (count_q != 2'd0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i && !flush_i;

  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ent
      always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          mem_q[gi] <= {WIDTH{1'b0}};
        end else if (push && (wr_ptr_q == gi)) begin
          mem_q[gi] <= in_data_i;
        end
      end
    end
  endgenerate

  always @(posedge core_clk_i) begin
    if (!reset_n_i || flush_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'd1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'd1;
      end
    end
  end

endmodule // rgh_fifo2

/* File: verilog/rgh_gate_ctrl.v */
// reading gate control and result handshake of a code reader
// assumes the control byte and parameter writes are synchronous to
// core_clk_i and the decoder side keeps its results until accepted
//
// Behaviour
// RULE1 - mode byte picks plain (0) or acknowledge handshake (1), plain after reset
// RULE2 - in handshake mode a new result waits until the shown one is acknowledged
// RULE3 - acknowledging the last pending result clears the result image to zero
// RULE4 - control bit 0.0 rising opens the gate, falling closes it
// RULE5 - either edge of control bit 0.4 acknowledges, only in handshake mode
// RULE6 - rising control bit 0.5 drops stored results and clears input images
// RULE7 - data reset also aborts fragmentation, dropping partly sent results
// RULE8 - data reset keeps device status, toggle bytes and gate state
// RULE9 - in plain mode each new result overwrites the image
// RULE10 - controller must use handshake when several results fit in one gate
// RULE11 - gate parameter byte 0 enables automatic gate repeat when 1
// RULE12 - end mode 0 none, 1 count, 2 table, 3 identifiers, 4 reference match
// RULE13 - automatic repeat reopens the gate after a 16-bit millisecond delay
// RULE14 - gate is forced shut after a 16-bit millisecond limit, 0 disables
// RULE15 - count end mode ends the gate only at the configured code count; code ends at code count >= limit, never with limit 0
// RULE16 - decoder state image bit 0.0 shows the gate state, 1 is open
// RULE17 - unused control byte bits are ignored
`timescale 1ns/10ps
`include "rgh_defines.vh"

module rgh_gate_ctrl #(
  parameter CYC_PER_MS = `RGH_CYC_PER_MS
) (
  // clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // cyclic control byte from the controller
  input wire [7:0] ctrl_byte_i,
  // activation parameter port
  input wire act_param_we_i,
  input wire [2:0] act_param_addr_i,
  input wire [7:0] act_param_wdata_i,
  output reg [7:0] act_param_rdata_o,
  // gate control parameter port
  input wire gate_param_we_i,
  input wire [2:0] gate_param_addr_i,
  input wire [7:0] gate_param_wdata_i,
  output reg [7:0] gate_param_rdata_o,
  // decoder results
  input wire result_valid_i,
  input wire [`RGH_RES_W-1:0] result_data_i,
  output reg result_ready_o,
  // completeness inputs from the decoder side
  input wire [7:0] code_count_i,
  input wire [7:0] max_code_count_i,
  input wire table_done_i,
  input wire ident_done_i,
  input wire refcmp_ok_i,
  // input images toward the controller
  output reg [`RGH_RES_W-1:0] result_image_o,
  output reg [7:0] decoder_state_o,
  output reg [7:0] result_toggle_o,
  output reg [7:0] ack_toggle_o,
  // gate and reset signals to the other modules
  output reg gate_open_o,
  output reg data_reset_o,
  output reg frag_abort_o
);

  localparam ST_IDLE = 2'd0;
  localparam ST_OPEN = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam [14:0] PRESC_MAX = CYC_PER_MS[14:0] - 15'h0001;

  // true when a byte offset matches, used for reads and writes
  function sel;
    input [2:0] addr;
    input [2:0] ofs;
    begin
      sel = (addr == ofs);
    end
  endfunction

  // parameter registers
  reg [7:0] act_mode_q;
  reg [7:0] auto_q;
  reg [7:0] end_mode_q;
  reg [15:0] dly_ms_q;
  reg [15:0] max_ms_q;

  // control byte history
  reg gate_prev_q;
  reg ack_prev_q;
  reg rst_prev_q;

  // gate machine
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [14:0] presc_q;
  reg [15:0] ms_q;
  reg gate_d;

  // image state
  reg shown_q;
  reg ovf_q;

  wire hs_mode;
  wire gate_rise;
  wire gate_fall;
  wire ack_evt;
  wire rst_evt;
  wire ms_tick;
  wire end_hit;
  wire max_hit;
  wire dly_done;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`RGH_RES_W-1:0] fifo_out_data;
  wire pop;
  reg end_sel;

  assign hs_mode = (act_mode_q == `RGH_ACT_MODE_ACK); // [RULE1]
  // only bits 0, 4 and 5 are looked at
  assign gate_rise = ctrl_byte_i[`RGH_CTL_GATE_BIT] && !gate_prev_q; // [RULE4] [RULE17]
  assign gate_fall = !ctrl_byte_i[`RGH_CTL_GATE_BIT] && gate_prev_q; // [RULE4]
  assign ack_evt = hs_mode &&
    (ctrl_byte_i[`RGH_CTL_ACK_BIT] != ack_prev_q); // [RULE5]
  assign rst_evt = ctrl_byte_i[`RGH_CTL_RST_BIT] && !rst_prev_q; // [RULE6]

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      gate_prev_q <= 1'b0;
      ack_prev_q <= 1'b0;
      rst_prev_q <= 1'b0;
    end else begin
      gate_prev_q <= ctrl_byte_i[`RGH_CTL_GATE_BIT];
      ack_prev_q <= ctrl_byte_i[`RGH_CTL_ACK_BIT];
      rst_prev_q <= ctrl_byte_i[`RGH_CTL_RST_BIT];
    end
  end

  // parameter writes and registered read back
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      act_mode_q <= `RGH_ACT_MODE_RST; // [RULE1]
      auto_q <= `RGH_GATE_AUTO_RST; // [RULE11]
      end_mode_q <= `RGH_GATE_END_RST; // [RULE12]
      dly_ms_q <= `RGH_GATE_DLY_RST;
      max_ms_q <= `RGH_GATE_MAX_RST;
    end else begin
      if (act_param_we_i && sel(act_param_addr_i, `RGH_ACT_MODE_OFS)) begin
        act_mode_q <= act_param_wdata_i;
      end
      if (gate_param_we_i) begin
        if (sel(gate_param_addr_i, `RGH_GATE_AUTO_OFS)) begin
          auto_q <= gate_param_wdata_i;
        end else if (sel(gate_param_addr_i, `RGH_GATE_END_OFS)) begin
          end_mode_q <= gate_param_wdata_i;
        end else if (sel(gate_param_addr_i, `RGH_GATE_DLY_LO_OFS)) begin
          dly_ms_q[7:0] <= gate_param_wdata_i;
        end else if (sel(gate_param_addr_i, `RGH_GATE_DLY_HI_OFS)) begin
          dly_ms_q[15:8] <= gate_param_wdata_i;
        end else if (sel(gate_param_addr_i, `RGH_GATE_MAX_LO_OFS)) begin
          max_ms_q[7:0] <= gate_param_wdata_i;
        end else if (sel(gate_param_addr_i, `RGH_GATE_MAX_HI_OFS)) begin
          max_ms_q[15:8] <= gate_param_wdata_i;
        end
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      act_param_rdata_o <= 8'h00;
      gate_param_rdata_o <= 8'h00;
    end else begin
      if (sel(act_param_addr_i, `RGH_ACT_MODE_OFS)) begin
        act_param_rdata_o <= act_mode_q;
      end else begin
        act_param_rdata_o <= 8'h00;
      end
      if (sel(gate_param_addr_i, `RGH_GATE_AUTO_OFS)) begin
        gate_param_rdata_o <= auto_q;
      end else if (sel(gate_param_addr_i, `RGH_GATE_END_OFS)) begin
        gate_param_rdata_o <= end_mode_q;
      end else if (sel(gate_param_addr_i, `RGH_GATE_DLY_LO_OFS)) begin
        gate_param_rdata_o <= dly_ms_q[7:0];
      end else if (sel(gate_param_addr_i, `RGH_GATE_DLY_HI_OFS)) begin
        gate_param_rdata_o <= dly_ms_q[15:8];
      end else if (sel(gate_param_addr_i, `RGH_GATE_MAX_LO_OFS)) begin
        gate_param_rdata_o <= max_ms_q[7:0];
      end else if (sel(gate_param_addr_i, `RGH_GATE_MAX_HI_OFS)) begin
        gate_param_rdata_o <= max_ms_q[15:8];
      end else begin
        gate_param_rdata_o <= 8'h00;
      end
    end
  end

  // completeness check picked by the end mode; unknown codes never end
  always @* begin
    end_sel = 1'b0;
    case (end_mode_q)
      `RGH_END_NONE: end_sel = 1'b0; // [RULE12]
      `RGH_END_COUNT: end_sel = (max_code_count_i != 8'h00) &&
        (code_count_i >= max_code_count_i); // [RULE12] [RULE15]
      `RGH_END_TABLE: end_sel = table_done_i; // [RULE12]
      `RGH_END_IDENT: end_sel = ident_done_i; // [RULE12]
      `RGH_END_REFCMP: end_sel = refcmp_ok_i; // [RULE12]
      default: end_sel = 1'b0;
    endcase
  end

  assign end_hit = end_sel;
  // millisecond prescaler restarts whenever the state changes
  assign ms_tick = (presc_q == PRESC_MAX);
  assign max_hit = (max_ms_q != 16'h0000) && (ms_q == max_ms_q); // [RULE14]
  assign dly_done = (ms_q == dly_ms_q); // [RULE13]

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (gate_rise) begin
          state_d = ST_OPEN; // [RULE4]
        end else if (auto_q == `RGH_AUTO_ON) begin
          state_d = ST_WAIT; // [RULE11]
        end
      end
      ST_OPEN: begin
        if (gate_fall || max_hit || end_hit) begin
          state_d = ST_IDLE; // [RULE4] [RULE14]
        end
      end
      ST_WAIT: begin
        if (gate_rise) begin
          state_d = ST_OPEN;
        end else if (auto_q != `RGH_AUTO_ON) begin
          state_d = ST_IDLE; // [RULE13]
        end else if (dly_done) begin
          state_d = ST_OPEN; // [RULE13]
        end
      end
      default: state_d = ST_IDLE;
    endcase
    gate_d = (state_d == ST_OPEN);
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      presc_q <= 15'h0000;
      ms_q <= 16'h0000;
      gate_open_o <= 1'b0;
    end else begin
      state_q <= state_d;
      gate_open_o <= gate_d; // [RULE16]
      if (state_d != state_q) begin
        presc_q <= 15'h0000;
        ms_q <= 16'h0000;
      end else if (ms_tick) begin
        presc_q <= 15'h0000;
        if (ms_q != 16'hffff) begin
          ms_q <= ms_q + 16'h0001;
        end
      end else begin
        presc_q <= presc_q + 15'h0001;
      end
    end
  end

  // result path through the two-entry buffer
  rgh_fifo2 #(
    .WIDTH(`RGH_RES_W)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .flush_i(rst_evt),
    .in_valid_i(result_valid_i),
    .in_data_i(result_data_i),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(pop)
  );

  // plain mode takes the next result unless a data reset flushes it, handshake waits for ack while a result is shown
  assign pop = fifo_out_valid && !rst_evt &&
    (!hs_mode || !shown_q || ack_evt); // [RULE2] [RULE9]

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      result_ready_o <= 1'b0;
    end else begin
      result_ready_o <= fifo_in_ready;
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      result_image_o <= {`RGH_RES_W{1'b0}};
      shown_q <= 1'b0;
      ovf_q <= 1'b0;
      result_toggle_o <= 8'h00;
      ack_toggle_o <= 8'h00;
      data_reset_o <= 1'b0;
      frag_abort_o <= 1'b0;
    end else begin
      data_reset_o <= rst_evt;
      frag_abort_o <= rst_evt; // [RULE7]
      if (ack_evt) begin
        ack_toggle_o <= ack_toggle_o + 8'h01;
      end
      if (rst_evt) begin
        // toggles and the gate state survive a data reset
        result_image_o <= {`RGH_RES_W{1'b0}}; // [RULE6] [RULE8]
        shown_q <= 1'b0;
      end else if (pop) begin
        result_image_o <= fifo_out_data; // [RULE9]
        shown_q <= 1'b1;
        result_toggle_o <= result_toggle_o + 8'h01;
      end else if (ack_evt && shown_q) begin
        result_image_o <= {`RGH_RES_W{1'b0}}; // [RULE3]
        shown_q <= 1'b0;
      end
      // a reject in the same cycle as a data reset stays flagged
      if (result_valid_i && !fifo_in_ready) begin
        ovf_q <= 1'b1;
      end else if (rst_evt) begin
        ovf_q <= 1'b0; // [RULE6]
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      decoder_state_o <= 8'h00;
    end else begin
      decoder_state_o <= 8'h00;
      decoder_state_o[`RGH_ST_GATE_BIT] <= gate_d; // [RULE16] [RULE8]
      decoder_state_o[`RGH_ST_NEW_BIT] <= shown_q;
      decoder_state_o[`RGH_ST_MORE_BIT] <= fifo_out_valid;
      decoder_state_o[`RGH_ST_OVF_BIT] <= ovf_q;
    end
  end

endmodule // rgh_gate_ctrl

/* File: tb/rgh_gate_ctrl_sva.sv */
// port assertions for the reading gate and handshake control
// assumes one clock and a synchronous active low reset
`timescale 1ns/10ps
`include "rgh_defines.vh"

module rgh_gate_ctrl_sva (
  // clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // controller byte
  input wire [7:0] ctrl_byte_i,
  // images and pulses
  input wire [`RGH_RES_W-1:0] result_image_o,
  input wire [7:0] decoder_state_o,
  input wire [7:0] result_toggle_o,
  input wire [7:0] ack_toggle_o,
  input wire gate_open_o,
  input wire data_reset_o,
  input wire frag_abort_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_gate_opens: assert property (
    $rose(ctrl_byte_i[0]) |-> ##[1:2] gate_open_o)
    else $error("gate did not open");
  a_gate_closes: assert property (
    $fell(ctrl_byte_i[0]) |-> ##[1:2] !gate_open_o)
    else $error("gate did not close");
  a_state_gate: assert property (
    gate_open_o == decoder_state_o[0])
    else $error("state gate bit differs");
  a_reset_pulse: assert property (
    $rose(ctrl_byte_i[5]) |-> ##[1:2] data_reset_o ##1 !data_reset_o)
    else $error("data reset pulse wrong");
  a_frag_abort: assert property (
    frag_abort_o == data_reset_o)
    else $error("fragment abort differs");
  a_reset_clears: assert property (
    data_reset_o |-> ##[0:1] result_image_o == 0)
    else $error("image kept on data reset");
  a_reset_keeps: assert property (
    data_reset_o |-> $stable(result_toggle_o) && $stable(ack_toggle_o)
      && $stable(gate_open_o))
    else $error("data reset touched kept state");
  a_ack_step: assert property (
    $changed(ack_toggle_o) |-> ack_toggle_o == $past(ack_toggle_o) + 8'h01
      && $past(ctrl_byte_i[4], 1) != $past(ctrl_byte_i[4], 3))
    else $error("ack toggle step wrong");
  a_res_step: assert property (
    $changed(result_toggle_o) |->
      result_toggle_o == $past(result_toggle_o) + 8'h01)
    else $error("result toggle step wrong");

  cover property ($rose(gate_open_o));
  cover property (data_reset_o);
  cover property ($changed(ack_toggle_o));
  cover property (decoder_state_o[4]);
endmodule // rgh_gate_ctrl_sva

bind rgh_gate_ctrl rgh_gate_ctrl_sva u_sva (
  .core_clk_i, .reset_n_i, .ctrl_byte_i, .result_image_o,
  .decoder_state_o, .result_toggle_o, .ack_toggle_o, .gate_open_o,
  .data_reset_o, .frag_abort_o
);

/* File: tb/rgh_plc_model.sv */
// controller model driving the cyclic control byte
// assumes the bench calls its tasks; every change lands on a clock edge
`timescale 1ns/10ps

module rgh_plc_model (
  // clock
  input wire core_clk_i,
  // noise for the free control bits
  input wire [4:0] noise_i,
  // control byte toward the device
  output wire [7:0] ctrl_byte_o
);
  reg gate_q = 1'b0;
  reg ack_q = 1'b0;
  reg rst_q = 1'b0;

  // free bits carry noise that the device must ignore
  assign ctrl_byte_o = {noise_i[4:3], rst_q, ack_q, noise_i[2:0], gate_q};

  task set_gate(input val);
    begin
      @(posedge core_clk_i);
      gate_q <= val;
    end
  endtask

  task ack;
    begin
      @(posedge core_clk_i);
      ack_q <= ~ack_q;
    end
  endtask

  task dreset;
    begin
      @(posedge core_clk_i);
      rst_q <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_q <= 1'b0;
    end
  endtask
endmodule // rgh_plc_model

/* File: tb/test_rgh_gate_ctrl.sv */
// self-checking bench for the reading gate and handshake control
// assumes the controller model and the bound port checker
`timescale 1ns/10ps

module test_rgh_gate_ctrl;
  localparam K_ARD = 4'h0, K_GRD = 4'h1, K_IMG = 4'h2, K_ST = 4'h3;
  localparam K_RTG = 4'h4, K_ATG = 4'h5, K_GATE = 4'h6, K_RDY = 4'h7;
  localparam K_DRS = 4'h8;
  reg core_clk_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg awe = 1'b0, gwe = 1'b0, rv = 1'b0;
  reg [2:0] pa = 3'h0;
  reg [7:0] pd = 8'h00;
  reg [31:0] rd = 32'h0000_0000, seed = 32'h0000_5bfa, v;
  reg [4:0] trig = 5'h00;
  reg [3:0] k;
  reg [31:0] qv[$], sent[$];
  reg [3:0] qk[$];
  wire [7:0] ctrl, ard, grd, st, rtg, atg;
  wire [31:0] img;
  wire rrdy, gate, drs, fab;
  // trig[1] reaches the count, trig[0] zeroes the count limit
  wire [7:0] cnt = trig[1] ? 8'h02 : 8'h01;
  wire [7:0] cmax = trig[0] ? 8'h00 : 8'h02;
  reg [3:0] n_drs = 4'h0, n_fab = 4'h0;
  integer error_cnt = 0, n_compared = 0, cyc = 0, m;
  event smp, cmp_done;

  rgh_plc_model plc (.core_clk_i(core_clk_i), .noise_i(seed[4:0]),
    .ctrl_byte_o(ctrl));
  rgh_gate_ctrl #(.CYC_PER_MS(4)) dut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ctrl_byte_i(ctrl),
    .act_param_we_i(awe), .act_param_addr_i(pa), .act_param_wdata_i(pd),
    .act_param_rdata_o(ard), .gate_param_we_i(gwe),
    .gate_param_addr_i(pa), .gate_param_wdata_i(pd),
    .gate_param_rdata_o(grd), .result_valid_i(rv), .result_data_i(rd),
    .result_ready_o(rrdy), .code_count_i(cnt),
    .max_code_count_i(cmax), .table_done_i(trig[2]),
    .ident_done_i(trig[3]), .refcmp_ok_i(trig[4]), .result_image_o(img),
    .decoder_state_o(st), .result_toggle_o(rtg), .ack_toggle_o(atg),
    .gate_open_o(gate), .data_reset_o(drs), .frag_abort_o(fab));

  // counts reset pulses; a pulse counts once for every cycle it stays high
  always @(posedge core_clk_i) begin
    if (drs) n_drs <= n_drs + 4'h1;
    if (fab) n_fab <= n_fab + 4'h1;
  end

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  always @(posedge core_clk_i) begin
    seed <= lfsr(seed);
    cyc = cyc + 1;
    if (cyc == 1500) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end

  task cmp_b(input [63:0] nm, input [7:0] e, input [7:0] s);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  task cmp_w(input [63:0] nm, input [31:0] e, input [31:0] s);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  // oldest note is compared against what the outputs show now
  always begin
    @(smp);
    k = qk.pop_front();
    v = qv.pop_front();
    case (k)
      K_ARD: cmp_b("act_rd", v[7:0], ard);
      K_GRD: cmp_b("gate_rd", v[7:0], grd);
      K_IMG: cmp_w("image", v, img);
      K_ST: cmp_b("state", v[7:0], st);
      K_RTG: cmp_b("res_tog", v[7:0], rtg);
      K_ATG: cmp_b("ack_tog", v[7:0], atg);
      K_GATE: cmp_b("gate", v[7:0], {7'h00, gate});
      K_DRS: cmp_b("dreset", v[7:0], {n_fab, n_drs});
      default: cmp_b("ready", v[7:0], {7'h00, rrdy});
    endcase
    -> cmp_done;
  end

  task note(input [3:0] kk, input [31:0] e);
    begin
      qk.push_back(kk);
      qv.push_back(e);
      -> smp;
      @(cmp_done);
    end
  endtask

  task chk(input [3:0] kk, input [7:0] e);
    note(kk, {24'h00_0000, e});
  endtask

  task wt(input integer n);
    begin
      repeat (n) @(posedge core_clk_i);
      #1;
    end
  endtask

  task wr(input g, input [2:0] a, input [7:0] d);
    begin
      @(posedge core_clk_i);
      gwe <= g;
      awe <= ~g;
      pa <= a;
      pd <= d;
      @(posedge core_clk_i);
      gwe <= 1'b0;
      awe <= 1'b0;
    end
  endtask

  task rd_chk(input g, input [2:0] a, input [7:0] e);
    begin
      @(posedge core_clk_i);
      pa <= a;
      wt(2);
      chk(g ? K_GRD : K_ARD, e);
    end
  endtask

  task push(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge core_clk_i);
        rv <= 1'b1;
        rd <= seed;
        sent.push_back(seed);
      end
      @(posedge core_clk_i);
      rv <= 1'b0;
    end
  endtask

  task wgate(input val);
    integer n;
    begin
      n = 0;
      while (gate !== val && n < 60) begin
        wt(1);
        n = n + 1;
      end
      chk(K_GATE, {7'h00, val});
    end
  endtask

  task fin(input [79:0] nm);
    $display("test %0s done", nm);
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    for (m = 0; m < 8; m = m + 1)
      rd_chk(1'b1, m[2:0], m == 1 ? 8'h01 : 8'h00);
    rd_chk(1'b0, 3'h0, 8'h00);
    rd_chk(1'b0, 3'h2, 8'h00);
    fin("defaults");
    plc.set_gate(1'b1);
    wt(3);
    chk(K_GATE, 8'h01);
    push(2);
    wt(4);
    note(K_IMG, sent[1]);
    chk(K_RTG, 8'h02);
    chk(K_ST, 8'h03);
    plc.ack;
    wt(4);
    chk(K_ATG, 8'h00);
    plc.dreset;
    wt(4);
    note(K_IMG, 32'h0000_0000);
    chk(K_DRS, 8'h11);
    chk(K_ST, 8'h01);
    chk(K_RTG, 8'h02);
    plc.set_gate(1'b0);
    wt(3);
    chk(K_GATE, 8'h00);
    fin("plain");
    wr(1'b0, 3'h0, 8'h01);
    rd_chk(1'b0, 3'h0, 8'h01);
    sent.delete();
    push(3);
    // a fourth word against a full buffer is refused
    @(posedge core_clk_i);
    rv <= 1'b1;
    rd <= 32'hdead_beef;
    repeat (3) @(posedge core_clk_i);
    rv <= 1'b0;
    wt(3);
    note(K_IMG, sent[0]);
    chk(K_ST, 8'h1a);
    chk(K_RDY, 8'h00);
    for (m = 1; m < 4; m = m + 1) begin
      plc.ack;
      wt(4);
      note(K_IMG, m < 3 ? sent[m] : 32'h0000_0000);
      chk(K_ATG, m[7:0]);
    end
    chk(K_ST, 8'h10);
    chk(K_RDY, 8'h01);
    chk(K_RTG, 8'h05);
    plc.dreset;
    wt(4);
    chk(K_ST, 8'h00);
    chk(K_ATG, 8'h03);
    chk(K_DRS, 8'h22);
    fin("handshake");
    wr(1'b1, 3'h1, 8'h00);
    wr(1'b1, 3'h4, 8'h02);
    rd_chk(1'b1, 3'h4, 8'h02);
    plc.set_gate(1'b1);
    wt(4);
    chk(K_GATE, 8'h01);
    wt(10);
    chk(K_GATE, 8'h00);
    plc.set_gate(1'b0);
    wr(1'b1, 3'h2, 8'h01);
    wr(1'b1, 3'h0, 8'h01);
    wgate(1'b1);
    wgate(1'b0);
    wgate(1'b1);
    wr(1'b1, 3'h0, 8'h00);
    wgate(1'b0);
    wt(20);
    chk(K_GATE, 8'h00);
    wr(1'b1, 3'h4, 8'h00);
    fin("timing");
    // 5 is an unknown end code, 6 is count mode with a zero limit
    for (m = 0; m < 7; m = m + 1) begin
      wr(1'b1, 3'h1, (m == 6) ? 8'h01 : m[7:0]);
      plc.set_gate(1'b1);
      wt(3);
      chk(K_GATE, 8'h01);
      @(posedge core_clk_i);
      trig <= (m == 0) ? 5'h1e : (m == 5) ? 5'h1f :
        (m == 6) ? 5'h03 : (5'h01 << m);
      wt(4);
      chk(K_GATE, {7'h00, m == 0 || m > 4});
      @(posedge core_clk_i);
      trig <= 5'h00;
      plc.set_gate(1'b0);
      wt(3);
    end
    fin("end_modes");
    wrap_up;
  end
endmodule // test_rgh_gate_ctrl
